//--- bench/pwmr_gate_model.sv
// gate driver model: flags shoot-through on any top/bottom pair
`timescale 1ns/1ps
`default_nettype none

module pwmr_gate_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // gate pins and the polarity they are wired for
  input  wire logic [5:0] pwm_pin,
  input  wire logic       top_inv,
  input  wire logic       bot_inv,
  input  wire logic       arm,       // watch only once polarity has settled
  // count of cycles with both switches of a pair conducting
  output logic      [7:0] overlap_cnt
);
  // ---------------------------------------------------------------
  // conduction decode
  // ---------------------------------------------------------------
  logic [5:0] on_w; // a switch conducts while its pin is at its active level
  logic       hit_w;
  assign on_w  = pwm_pin ^ {3{bot_inv, top_inv}};
  assign hit_w = |(on_w[4:0] & on_w[5:1] & 5'h15); // pairs 0/1, 2/3, 4/5

  // saturating count so a long fault never wraps back to zero
  always_ff @(posedge clk) begin
    if (!reset_n) overlap_cnt <= 8'h00;
    else if (arm && hit_w && overlap_cnt != 8'hff) overlap_cnt <= overlap_cnt + 8'h01;
  end
endmodule : pwmr_gate_model

`default_nettype wire

//--- bench/tb.sv
// self-checking testbench for the pwm output and reload block
`timescale 1ns/1ps
`default_nettype none

module tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clk = 1'b0, reset_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, reload_irq;
  logic [1:0] bresp, rresp;
  logic [5:0] pwm_pin;
  logic top_inv = 0, bot_inv = 0, arm = 0;
  logic [7:0] overlap_cnt;
  int mismatches = 0, samples_checked = 0;
  // ctrl bit masks
  localparam logic [31:0] B_EN = 32'h1 << pwmr_pkg::CTRL_EN;
  localparam logic [31:0] B_OK = 32'h1 << pwmr_pkg::CTRL_LOAD_OKAY;
  localparam logic [31:0] B_FL = 32'h1 << pwmr_pkg::CTRL_FLAG;
  localparam logic [31:0] B_IE = 32'h1 << pwmr_pkg::CTRL_IRQEN;
  localparam logic [31:0] B_ED = 32'h1 << pwmr_pkg::CTRL_EDGE;

  always #5 clk = ~clk;

  pwmr_top uut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pwm_pin(pwm_pin), .reload_irq(reload_irq));

  pwmr_gate_model gate (.clk(clk), .reset_n(reset_n), .pwm_pin(pwm_pin),
    .top_inv(top_inv), .bot_inv(bot_inv), .arm(arm),
    .overlap_cnt(overlap_cnt));

  // ---------------------------------------------------------------
  // reporting
  // ---------------------------------------------------------------
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  task automatic check_word(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : check_word

  task automatic check_resp(input string nm, input logic [1:0] e, g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : check_resp

  // ---------------------------------------------------------------
  // axi4-lite master; entered just after a rising edge
  // ---------------------------------------------------------------
  // bready and rready stay high once raised, so back-to-back calls never
  // drive them twice in one time step; only the watchdog ends a wait
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    awaddr <= a; wdata <= d; wstrb <= 4'hf;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0; wvalid <= 1'b0;
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata; r = rresp;
  endtask : axi_rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    check_resp("bresp", pwmr_pkg::RESP_OK, r);
  endtask : wr

  task automatic rd_check(input string nm, input logic [7:0] a,
                          input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    check_word(nm, e, d & m);
  endtask : rd_check

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // independent override under each polarity pair, unit disabled
  task automatic t_polarity;
    logic [1:0] p;
    logic [5:0] lvl;
    lvl = 6'b010101;
    wr(pwmr_pkg::OFF_OUT, {18'h0, lvl, 8'h3f});
    for (int i = 0; i < 4; i++) begin
      p = 2'(i);
      wr(pwmr_pkg::OFF_CTRL, (32'h7 << pwmr_pkg::CTRL_INDEP) |
                             (32'(p) << pwmr_pkg::CTRL_TOPINV));
      repeat (6) @(posedge clk);
      check_word("pins", {26'h0, lvl ^ {3{p[1], p[0]}}}, {26'h0, pwm_pin});
    end
    wr(pwmr_pkg::OFF_OUT, 32'h0);
  endtask : t_polarity

  // complementary override: even drives pair, odd selects complement
  task automatic t_complement;
    logic [5:0] lv [3];
    logic [5:0] ex [3];
    lv = '{6'b111111, 6'b101010, 6'b000000};
    ex = '{6'b010101, 6'b101010, 6'b000000};
    wr(pwmr_pkg::OFF_CTRL, 32'h0);
    wr(pwmr_pkg::OFF_DEADTIME_COUNT, 32'h3);
    // levels cleared before enables go on, so no stray deadtime
    wr(pwmr_pkg::OFF_OUT, 32'h3f);
    repeat (4) @(posedge clk);
    arm <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(pwmr_pkg::OFF_OUT, {18'h0, lv[i], 8'h3f});
      repeat (12) @(posedge clk);
      check_word("pins", {26'h0, ex[i]}, {26'h0, pwm_pin});
    end
    check_word("overlap", 32'h0, {24'h0, overlap_cnt});
    arm <= 1'b0;
    wr(pwmr_pkg::OFF_OUT, 32'h0);
  endtask : t_complement

  // load on enable, flag, irq, disable keeps flag, re-enable reuses
  task automatic t_load;
    wr(pwmr_pkg::OFF_MOD, 32'h10);
    wr(pwmr_pkg::OFF_VAL0, 32'h8);
    // load_okay is read before it is written as one
    rd_check("load_okay", pwmr_pkg::OFF_CTRL, B_OK, 32'h0);
    wr(pwmr_pkg::OFF_CTRL, B_EN | B_OK | B_IE | B_ED);
    rd_check("actmod", pwmr_pkg::OFF_ACTMOD, 32'h7fff, 32'h10);
    rd_check("flags", pwmr_pkg::OFF_CTRL, B_OK | B_FL, B_FL);
    check_word("irq", 32'h1, {31'h0, reload_irq});
    wr(pwmr_pkg::OFF_CTRL, B_IE | B_FL);
    rd_check("flag kept", pwmr_pkg::OFF_CTRL, B_FL, B_FL);
    rd_check("counter", pwmr_pkg::OFF_CNT, 32'h7fff, 32'h0);
    wr(pwmr_pkg::OFF_CTRL, B_IE);
    rd_check("flag clr", pwmr_pkg::OFF_CTRL, B_FL, 32'h0);
    check_word("irq", 32'h0, {31'h0, reload_irq});
    wr(pwmr_pkg::OFF_MOD, 32'h20);
    wr(pwmr_pkg::OFF_CTRL, B_EN | B_ED);
    rd_check("flag en", pwmr_pkg::OFF_CTRL, B_FL, B_FL);
    rd_check("reuse", pwmr_pkg::OFF_ACTMOD, 32'h7fff, 32'h10);
    wr(pwmr_pkg::OFF_CTRL, 32'h0);
  endtask : t_load

  // unmapped address answers with slave error
  task automatic t_unmapped;
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(8'h18, 32'h1, r);
    check_resp("bresp", pwmr_pkg::RESP_ERR, r);
    axi_rd(8'h18, d, r);
    check_resp("rresp", pwmr_pkg::RESP_ERR, r);
  endtask : t_unmapped

  // reload every sixteenth opportunity: staged modulus waits for it
  task automatic t_rate;
    logic [31:0] run;
    run = B_EN | B_ED | (32'hf << pwmr_pkg::CTRL_RELOAD_RATE_SELECT);
    wr(pwmr_pkg::OFF_MOD, 32'h4);
    wr(pwmr_pkg::OFF_CTRL, run | B_OK);
    wr(pwmr_pkg::OFF_MOD, 32'h8);
    rd_check("load_okay rate", pwmr_pkg::OFF_CTRL, B_OK, 32'h0);
    wr(pwmr_pkg::OFF_CTRL, run | B_OK);
    rd_check("rate wait", pwmr_pkg::OFF_ACTMOD, 32'h7fff, 32'h4);
    repeat (80) @(posedge clk);
    rd_check("rate load", pwmr_pkg::OFF_ACTMOD, 32'h7fff, 32'h8);
    rd_check("load_okay self", pwmr_pkg::OFF_CTRL, B_OK, 32'h0);
    wr(pwmr_pkg::OFF_CTRL, 32'h0);
  endtask : t_rate

  // mid-run reset, then a first enable without load_okay: duty zero,
  // so even pins stay inactive and odd pins are their complement
  task automatic t_first_en;
    wr(pwmr_pkg::OFF_CTRL, B_IE | B_ED);
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd_check("ctrl rst2", pwmr_pkg::OFF_CTRL, 32'hffffffff, 32'h0);
    wr(pwmr_pkg::OFF_CTRL, B_EN | B_ED);
    repeat (8) @(posedge clk);
    check_word("pins dflt", 32'h2a, {26'h0, pwm_pin});
    rd_check("flag dflt", pwmr_pkg::OFF_CTRL, B_OK | B_FL, B_FL);
    wr(pwmr_pkg::OFF_CTRL, 32'h0);
  endtask : t_first_en

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd_check("ctrl rst", pwmr_pkg::OFF_CTRL, 32'hffffffff, 32'h0);
    check_word("pins rst", 32'h0, {26'h0, pwm_pin});
    t_polarity();
    t_complement();
    t_load();
    t_rate();
    t_unmapped();
    t_first_en();
    print_verdict();
  end

  // whole run needs a few hundred cycles
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
endmodule : tb

`default_nettype wire

//--- core/pwmr_pkg.sv
// package: register map, field layout and types for the pwm output/reload block
package pwmr_pkg;

  // ---------------------------------------------------------------
  // register byte offsets (aligned words)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00; // enables, rates, flags
  localparam logic [7:0] OFF_OUT    = 8'h04; // override enables and levels
  localparam logic [7:0] OFF_MOD    = 8'h08; // modulus staging
  localparam logic [7:0] OFF_DEADTIME_COUNT   = 8'h0c; // deadtime count
  localparam logic [7:0] OFF_CNT    = 8'h10; // counter (read only)
  localparam logic [7:0] OFF_ACTMOD = 8'h14; // active modulus (read only)
  localparam logic [7:0] OFF_VAL0   = 8'h20; // duty value 0, 4 bytes apart

  // ---------------------------------------------------------------
  // ctrl field positions
  // ---------------------------------------------------------------
  localparam int CTRL_EN     = 0;  // unit_enable
  localparam int CTRL_LOAD_OKAY   = 1;  // load_okay
  localparam int CTRL_FLAG   = 2;  // reload_flag
  localparam int CTRL_IRQEN  = 3;  // reload_irq_enable
  localparam int CTRL_HALF   = 4;  // half-cycle reloads
  localparam int CTRL_EDGE   = 5;  // edge aligned
  localparam int CTRL_TOPINV = 6;  // top_polarity_invert
  localparam int CTRL_BOTINV = 7;  // bottom_polarity_invert
  localparam int CTRL_PRS_LO = 8;  // prescale_select_lo
  localparam int CTRL_PRS_HI = 9;  // prescale_select_hi
  localparam int CTRL_RELOAD_RATE_SELECT   = 12; // reload_rate_select, 4 bits
  localparam int CTRL_INDEP  = 16; // independent mode per pair, 3 bits
  localparam int CTRL_IVSEL  = 20; // initial_value_select per pair, 3 bits

  // out register: enables in [5:0], levels in [13:8]
  localparam int OUT_LVL = 8;

  localparam logic [1:0] RESP_OK  = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;

  // double-buffered generator parameters
  typedef struct packed {
    logic [1:0]  prescale;
    logic [14:0] modulus;
  } pwmr_load_t;

endpackage : pwmr_pkg

//--- core/pwmr_top.sv
// pwm output stage with override, polarity and parameter reload
`timescale 1ns/1ps
`default_nettype none

module pwmr_top #(
  parameter int NCH = 6,   // channel count
  parameter int DTW = 8    // deadtime counter width
) (
  // clock and reset
  input  wire  logic        clk,
  input  wire  logic        reset_n,
  // axi4-lite write
  input  wire  logic [7:0]  s_axi_awaddr,
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  // axi4-lite read
  input  wire  logic [7:0]  s_axi_araddr,
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready,
  // power stage gates and reload interrupt
  output logic [NCH-1:0]    pwm_pin,
  output logic              reload_irq
);

  initial begin
    if (NCH != 6) $error("pwmr_top: six channels only");
    if (DTW < 1 || DTW > 16) $error("pwmr_top: bad DTW");
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [31:0]     ctrl_reg;        // software control word
  logic [5:0]      ovr_en_reg;      // sw_override_enable
  logic [5:0]      ovr_lvl_reg;     // sw_drive_level
  logic [14:0]     mod_stage_reg;   // period_modulus staging
  logic [DTW-1:0]  deadtime_count_reg;        // deadtime_count
  logic [15:0]     val_stage_reg [6]; // duty_value staging
  logic [15:0]     val_act_reg   [6]; // duty_value buffers
  pwmr_pkg::pwmr_load_t act_reg;    // active prescale and modulus
  logic [14:0]     cnt_reg;         // generator counter
  logic            down_reg;        // counting down (center)
  logic [2:0]      pre_reg;         // prescale divider
  logic [3:0]      rate_reg;        // opportunity counter
  logic            en_d_reg;        // delayed enable for edge detect
  logic            first_reg;       // first pwm cycle after enable
  logic [5:0]      gated_reg;       // override owns pin
  logic [5:0]      drv_reg;         // pre-deadtime active levels
  logic [2:0]      src_prev_reg;    // last pair source level
  logic [DTW-1:0]  dt_cnt_reg [3];  // deadtime counters per pair
  logic [5:0]      pin_reg;         // registered pins

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  wire en      = ctrl_reg[pwmr_pkg::CTRL_EN];
  wire load_okay    = ctrl_reg[pwmr_pkg::CTRL_LOAD_OKAY];
  wire half    = ctrl_reg[pwmr_pkg::CTRL_HALF];
  wire edge_al = ctrl_reg[pwmr_pkg::CTRL_EDGE];
  wire [3:0] reload_rate_select = ctrl_reg[pwmr_pkg::CTRL_RELOAD_RATE_SELECT +: 4];
  wire [2:0] indep = ctrl_reg[pwmr_pkg::CTRL_INDEP +: 3];
  wire [2:0] ivsel = ctrl_reg[pwmr_pkg::CTRL_IVSEL +: 3];

  // prescaler tick: divisor 1,2,4,8
  wire [2:0] pre_mask = (3'(1) << act_reg.prescale) - 3'(1);
  wire tick = en && ((pre_reg & pre_mask) == pre_mask ||
                     act_reg.prescale == 2'd0);
  wire at_mod   = cnt_reg >= act_reg.modulus - 15'(1);
  wire at_start = tick && (edge_al ? at_mod : (down_reg && cnt_reg <= 15'(1)));
  wire at_mid   = tick && !edge_al && !down_reg && at_mod;
  // opportunities: start always, mid only center with half set
  wire opp      = at_start || (at_mid && half);
  wire en_rise  = en && !en_d_reg;
  wire rate_hit = rate_reg >= reload_rate_select;
  wire do_load  = (opp && rate_hit && load_okay) || (en_rise && load_okay);
  wire set_flag = opp || en_rise;

  // ---------------------------------------------------------------
  // axi4-lite slave, single outstanding per direction
  // ---------------------------------------------------------------
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  wire rd_go = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = rd_go;
  wire [7:0] wa = s_axi_awaddr;
  wire wa_val = wa >= pwmr_pkg::OFF_VAL0 &&
                wa < pwmr_pkg::OFF_VAL0 + 8'h18;
  wire [2:0] wa_idx = 3'((wa - pwmr_pkg::OFF_VAL0) >> 2);
  wire wa_ok = wa_val || wa == pwmr_pkg::OFF_CTRL ||
               wa == pwmr_pkg::OFF_OUT || wa == pwmr_pkg::OFF_MOD ||
               wa == pwmr_pkg::OFF_DEADTIME_COUNT;

  // byte-lane merge shared by every writable register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  st);
    for (int b = 0; b < 4; b++)
      if (st[b]) old[8*b +: 8] = nw[8*b +: 8];
    return old;
  endfunction : merge

  wire [31:0] ctrl_w = merge(ctrl_reg, s_axi_wdata, s_axi_wstrb);
  wire ctrl_wr = wr_go && wa == pwmr_pkg::OFF_CTRL;
  // flag: writing zero clears, hardware set wins; load_okay self clears
  wire flag_next = set_flag ||
    (ctrl_reg[pwmr_pkg::CTRL_FLAG] &&
     !(ctrl_wr && !ctrl_w[pwmr_pkg::CTRL_FLAG]));
  wire load_okay_next = !do_load &&
    (load_okay || (ctrl_wr && ctrl_w[pwmr_pkg::CTRL_LOAD_OKAY]));

  // read mux
  wire [7:0] ra = s_axi_araddr;
  wire ra_val = ra >= pwmr_pkg::OFF_VAL0 &&
                ra < pwmr_pkg::OFF_VAL0 + 8'h18;
  wire [2:0] ra_idx = 3'((ra - pwmr_pkg::OFF_VAL0) >> 2);
  logic [31:0] rd_word;
  logic        rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    rd_word = 32'h0;
    if (ra_val) rd_word = {16'h0, val_stage_reg[ra_idx]};
    else unique case (ra)
      pwmr_pkg::OFF_CTRL:   rd_word = ctrl_reg;
      pwmr_pkg::OFF_OUT:    rd_word = {18'h0, ovr_lvl_reg, 2'h0, ovr_en_reg};
      pwmr_pkg::OFF_MOD:    rd_word = {17'h0, mod_stage_reg};
      pwmr_pkg::OFF_DEADTIME_COUNT:   rd_word = 32'(deadtime_count_reg);
      pwmr_pkg::OFF_CNT:    rd_word = {17'h0, cnt_reg};
      pwmr_pkg::OFF_ACTMOD: rd_word = {17'h0, act_reg.modulus};
      default:              rd_ok = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // bus side registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_reg <= 32'h0; ovr_en_reg <= 6'h0; ovr_lvl_reg <= 6'h0;
      mod_stage_reg <= 15'h0; deadtime_count_reg <= '0;
      s_axi_bvalid <= 1'b0; s_axi_bresp <= pwmr_pkg::RESP_OK;
      s_axi_rvalid <= 1'b0; s_axi_rresp <= pwmr_pkg::RESP_OK;
      s_axi_rdata <= 32'h0;
    end else begin
      if (ctrl_wr) ctrl_reg <= ctrl_w;
      ctrl_reg[pwmr_pkg::CTRL_FLAG] <= flag_next;
      ctrl_reg[pwmr_pkg::CTRL_LOAD_OKAY] <= load_okay_next;
      if (wr_go && wa == pwmr_pkg::OFF_OUT) begin
        ovr_en_reg  <= 6'(merge({18'h0, ovr_lvl_reg, 2'h0, ovr_en_reg},
                                s_axi_wdata, s_axi_wstrb));
        ovr_lvl_reg <= 6'(merge({18'h0, ovr_lvl_reg, 2'h0, ovr_en_reg},
                                s_axi_wdata, s_axi_wstrb) >> pwmr_pkg::OUT_LVL);
      end
      if (wr_go && wa == pwmr_pkg::OFF_MOD)
        mod_stage_reg <= 15'(merge({17'h0, mod_stage_reg}, s_axi_wdata,
                                   s_axi_wstrb));
      if (wr_go && wa == pwmr_pkg::OFF_DEADTIME_COUNT)
        deadtime_count_reg <= DTW'(merge(32'(deadtime_count_reg), s_axi_wdata, s_axi_wstrb));
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wa_ok ? pwmr_pkg::RESP_OK : pwmr_pkg::RESP_ERR;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? pwmr_pkg::RESP_OK : pwmr_pkg::RESP_ERR;
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end
  end

  // duty staging and buffers; reset buffers give duty zero
  always_ff @(posedge clk) begin
    for (int i = 0; i < 6; i++) begin
      if (!reset_n) begin
        val_stage_reg[i] <= 16'h0;
        val_act_reg[i]   <= 16'h0;
      end else begin
        if (wr_go && wa_val && wa_idx == 3'(i))
          val_stage_reg[i] <= 16'(merge({16'h0, val_stage_reg[i]},
                                        s_axi_wdata, s_axi_wstrb));
        if (do_load) val_act_reg[i] <= val_stage_reg[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // generator counter and reload
  // ---------------------------------------------------------------
  // reset buffers give divisor one; modulus left as the staging reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      act_reg <= '0;
      cnt_reg <= 15'h0; down_reg <= 1'b0; pre_reg <= 3'h0;
      rate_reg <= 4'h0; en_d_reg <= 1'b0; first_reg <= 1'b0;
    end else begin
      en_d_reg <= en;
      if (do_load) begin
        act_reg.prescale <= {ctrl_reg[pwmr_pkg::CTRL_PRS_HI],
                             ctrl_reg[pwmr_pkg::CTRL_PRS_LO]};
        act_reg.modulus  <= mod_stage_reg;
      end
      if (opp || en_rise)
        rate_reg <= (rate_hit || en_rise) ? 4'h0 : rate_reg + 4'h1;
      if (!en) begin
        cnt_reg <= 15'h0; down_reg <= 1'b0; pre_reg <= 3'h0;
      end else begin
        pre_reg <= pre_reg + 3'h1;
        if (en_rise) first_reg <= 1'b1;
        else if (at_start) first_reg <= 1'b0;
        if (at_mid && do_load) begin
          down_reg <= 1'b1; cnt_reg <= mod_stage_reg - 15'(1);
        end else if (tick) begin
          if (edge_al) cnt_reg <= at_mod ? 15'h0 : cnt_reg + 15'h1;
          else if (at_mid) begin down_reg <= 1'b1; cnt_reg <= cnt_reg - 15'h1; end
          else if (at_start) begin down_reg <= 1'b0; cnt_reg <= 15'h1; end
          else cnt_reg <= down_reg ? cnt_reg - 15'h1 : cnt_reg + 15'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // generator compare and output selection
  // ---------------------------------------------------------------
  function automatic logic cmp(input logic [15:0] v, input logic [14:0] c);
    return !v[15] && (v[14:0] > c);
  endfunction : cmp

  logic [5:0] gen_out;
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      // first cycle: initial select chooses even or odd duty value
      logic [15:0] pv;
      pv = (first_reg && ivsel[p]) ? val_act_reg[2*p+1] : val_act_reg[2*p];
      gen_out[2*p]   = en && cmp(indep[p] ? val_act_reg[2*p] : pv, cnt_reg);
      gen_out[2*p+1] = en && (indep[p] ? cmp(val_act_reg[2*p+1], cnt_reg)
                                       : !cmp(pv, cnt_reg));
    end
  end

  // generator regains pin only at cycle start (or any time when idle)
  wire [5:0] gated_next = ovr_en_reg |
                          ((at_start || !en) ? 6'h0 : gated_reg);

  // active levels before deadtime
  logic [5:0] drv_next;
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      if (indep[p]) begin
        drv_next[2*p]   = gated_next[2*p] ? ovr_lvl_reg[2*p] : gen_out[2*p];
        drv_next[2*p+1] = gated_next[2*p+1] ? ovr_lvl_reg[2*p+1]
                                            : gen_out[2*p+1];
      end else if (gated_next[2*p]) begin
        drv_next[2*p]   = ovr_lvl_reg[2*p];
        drv_next[2*p+1] = ovr_lvl_reg[2*p+1] && !ovr_lvl_reg[2*p];
      end else begin
        drv_next[2*p]   = gen_out[2*p];
        drv_next[2*p+1] = gen_out[2*p+1];
      end
    end
  end

  // deadtime: source is the even level, counter restarts on every toggle
  logic [5:0] act_lvl;
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      logic busy;
      busy = !indep[p] && (dt_cnt_reg[p] != '0 ||
                           drv_reg[2*p] != src_prev_reg[p]);
      act_lvl[2*p]   = drv_reg[2*p]   && !busy;
      act_lvl[2*p+1] = drv_reg[2*p+1] && !busy;
    end
  end

  wire [5:0] pol_inv = {3{ctrl_reg[pwmr_pkg::CTRL_BOTINV],
                          ctrl_reg[pwmr_pkg::CTRL_TOPINV]}};
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gated_reg <= 6'h0; drv_reg <= 6'h0; src_prev_reg <= 3'h0;
      pin_reg <= 6'h0;
      for (int p = 0; p < 3; p++) dt_cnt_reg[p] <= '0;
    end else begin
      gated_reg <= gated_next;
      drv_reg   <= drv_next;
      pin_reg   <= act_lvl ^ pol_inv;
      for (int p = 0; p < 3; p++) begin
        src_prev_reg[p] <= drv_reg[2*p];
        // reload full programmed count on toggle: never shorter
        if (drv_reg[2*p] != src_prev_reg[p]) dt_cnt_reg[p] <= deadtime_count_reg;
        else if (dt_cnt_reg[p] != '0) dt_cnt_reg[p] <= dt_cnt_reg[p] - DTW'(1);
      end
    end
  end

  assign pwm_pin    = pin_reg;
  assign reload_irq = ctrl_reg[pwmr_pkg::CTRL_FLAG] &&
                      ctrl_reg[pwmr_pkg::CTRL_IRQEN];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_flag_sets: assert property (@(posedge clk) disable iff (!reset_n)
    set_flag |=> ctrl_reg[pwmr_pkg::CTRL_FLAG])
    else $error("reload flag not set");
  a_load_okay_clears: assert property (@(posedge clk) disable iff (!reset_n)
    do_load |=> !load_okay && act_reg.modulus == $past(mod_stage_reg))
    else $error("load did not complete");
  a_enable_flag: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(en) |-> ##1 ctrl_reg[pwmr_pkg::CTRL_FLAG])
    else $error("enable did not set flag");
  a_idle_counter: assert property (@(posedge clk) disable iff (!reset_n)
    !en ##1 !en |-> cnt_reg == 15'h0 && gen_out == 6'h0)
    else $error("counter ran while disabled");
  a_top_polarity: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> pin_reg[0] == ($past(act_lvl[0]) ^
                            $past(ctrl_reg[pwmr_pkg::CTRL_TOPINV])))
    else $error("top polarity wrong");
  a_bot_polarity: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> pin_reg[1] == ($past(act_lvl[1]) ^
                            $past(ctrl_reg[pwmr_pkg::CTRL_BOTINV])))
    else $error("bottom polarity wrong");
  a_indep_override: assert property (@(posedge clk) disable iff (!reset_n)
    indep[0] && ovr_en_reg[0] |=> drv_reg[0] == $past(ovr_lvl_reg[0]))
    else $error("override level ignored");
  a_odd_inactive: assert property (@(posedge clk) disable iff (!reset_n)
    !indep[1] && ovr_en_reg[2] && !ovr_lvl_reg[3] |=> !drv_reg[3])
    else $error("odd not deactivated");
  a_deadtime_gap: assert property (@(posedge clk) disable iff (!reset_n)
    !indep[0] && drv_reg[0] != src_prev_reg[0] |-> act_lvl[1:0] == 2'b00)
    else $error("no deadtime on toggle");

endmodule : pwmr_top

`default_nettype wire
